// ==== include/i2cab_pkg.sv ====
// Shared constants and types for the two-wire bus arbitration block
package i2cab_pkg;

    // ----
    // Device register port
    // ----
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STAT = 3'h1;
    localparam logic [2:0] REG_OWN = 3'h2;
    localparam logic [2:0] REG_SEC = 3'h3;
    localparam logic [2:0] REG_DATA = 3'h4;
    localparam int unsigned CTRL_MST = 0;
    localparam int unsigned CTRL_BUSY = 1;
    localparam int unsigned ST_AL = 0;
    localparam int unsigned ST_CALL = 1;
    localparam int unsigned ST_FRM = 2;
    localparam logic [7:0] ST_ALL = 8'h07;
    localparam logic [3:0] ACK_BIT = 4'h8;

    // ----
    // Timing
    // ----
    localparam int unsigned CLK_NS = 5;
    localparam int unsigned HALF_BIT_NS = 5000;
    localparam int unsigned HALF_BIT_CYC = HALF_BIT_NS / CLK_NS;

    // ----
    // Controller APB map
    // ----
    localparam logic [11:0] A_CMD = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_IRQ = 12'h008;
    localparam logic [11:0] A_MASK = 12'h00C;
    localparam logic [11:0] A_ADDR = 12'h010;
    localparam logic [2:0] OP_ENTER = 3'h1;
    localparam logic [2:0] OP_SEND = 3'h2;
    localparam logic [2:0] OP_STOP = 3'h3;
    localparam logic [2:0] OP_CFG = 3'h4;
    localparam int unsigned EV_MST = 0;
    localparam int unsigned EV_REFUSE = 1;
    localparam int unsigned EV_DONE = 2;
    localparam int unsigned EV_LOST = 3;
    localparam int unsigned EV_CALL = 4;

    // ----
    // State encodings
    // ----
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_LOW = 3'b010,
        M_HIGH = 3'b011,
        M_WAIT = 3'b100,
        M_STOP = 3'b101,
        M_STOP2 = 3'b110
    } i2cab_mst_t;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0000,
        H_CHK1 = 4'b0001,
        H_SETM = 4'b0010,
        H_CHK2 = 4'b0011,
        H_DROP = 4'b0100,
        H_TX = 4'b0101,
        H_POLL = 4'b0110,
        H_CLR = 4'b0111,
        H_STOP = 4'b1000,
        H_CFG1 = 4'b1001,
        H_CFG2 = 4'b1010
    } i2cab_host_t;

endpackage

// ==== include/i2cab_reg_if.sv ====
// Register port between the bus interface and its controller
`timescale 1ns/1ps
`default_nettype none
interface i2cab_reg_if;
    logic req;
    logic wr;
    logic [2:0] sel;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic ack;

    modport dev (input req, input wr, input sel, input wdata, output rdata, output ack);
    modport host (output req, output wr, output sel, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// ==== src/i2cab_dev.sv ====
// Two-wire bus interface with master arbitration and slave address match
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// (R01) Arbitration loss: become slave, frame is address
// (R02) Late loss compares data byte with addresses
// (R03) Match after late loss flags address call
// (R04) Host reads lost flag after every frame
// (R05) Master bit set mid-transfer joins as master
// (R06) Host checks bus free before master request
// (R07) Host then sets master select bit
// (R08) Host re-reads busy flag right after
// (R09) On loss release clock and data lines
module i2cab_dev #(
    parameter int unsigned HALF_CYC = i2cab_pkg::HALF_BIT_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register port
    i2cab_reg_if.dev rif,
    // Two-wire bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n
);

    // ----
    // State
    // ----
    typedef struct packed {
        logic scl_oe_n;
        logic sda_oe_n;
        logic scl_p;
        logic sda_p;
        logic busy;
        logic master_select_bit;
        logic al;
        logic call;
        logic frm;
        logic [6:0] own;
        logic [6:0] sec;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [3:0] bit_n;
        logic expect_addr;
        logic kick;
        i2cab_pkg::i2cab_mst_t state;
        logic [15:0] div;
        logic [7:0] rdata;
        logic ack;
    } i2cab_dev_t;

    i2cab_dev_t q;
    i2cab_dev_t n;
    logic rise;
    logic start;
    logic stop;
    logic tick;
    logic lost;

    // ----
    // Bus events
    // ----
    // Edges and conditions seen on the wires
    assign rise = !q.scl_p && scl_i;
    assign start = q.scl_p && scl_i && q.sda_p && !sda_i;
    assign stop = q.scl_p && scl_i && !q.sda_p && sda_i;
    assign tick = (q.div == 16'(HALF_CYC - 1));
    // Released a one but the wire reads low
    assign lost = rise && q.busy && q.master_select_bit && !q.bit_n[3] && q.sda_oe_n && !sda_i;

    // ----
    // Next state
    // ----
    // Register access, master engine, then bus monitor
    always_comb
    begin
        n = q;
        n.ack = 1'b0;
        n.scl_p = scl_i;
        n.sda_p = sda_i;
        n.div = (q.state == i2cab_pkg::M_IDLE || q.state == i2cab_pkg::M_WAIT || tick)
            ? 16'h0000 : q.div + 16'h0001;

        // Register port, one-cycle answer
        if (rif.req)
        begin
            n.ack = 1'b1;
            n.rdata = 8'h00;
            unique case (rif.sel)
                i2cab_pkg::REG_CTRL:
                begin
                    if (rif.wr)
                    begin
                        n.master_select_bit = rif.wdata[i2cab_pkg::CTRL_MST]; // [R05]
                    end
                    n.rdata[i2cab_pkg::CTRL_MST] = q.master_select_bit;
                    n.rdata[i2cab_pkg::CTRL_BUSY] = q.busy;
                end
                i2cab_pkg::REG_STAT:
                begin
                    if (rif.wr)
                    begin
                        n.al = q.al & ~rif.wdata[i2cab_pkg::ST_AL];
                        n.call = q.call & ~rif.wdata[i2cab_pkg::ST_CALL];
                        n.frm = q.frm & ~rif.wdata[i2cab_pkg::ST_FRM];
                    end
                    n.rdata[i2cab_pkg::ST_AL] = q.al;
                    n.rdata[i2cab_pkg::ST_CALL] = q.call;
                    n.rdata[i2cab_pkg::ST_FRM] = q.frm;
                end
                i2cab_pkg::REG_OWN:
                begin
                    if (rif.wr)
                    begin
                        n.own = rif.wdata[6:0];
                    end
                    n.rdata = {1'b0, q.own};
                end
                i2cab_pkg::REG_SEC:
                begin
                    if (rif.wr)
                    begin
                        n.sec = rif.wdata[6:0];
                    end
                    n.rdata = {1'b0, q.sec};
                end
                i2cab_pkg::REG_DATA:
                begin
                    if (rif.wr)
                    begin
                        n.tx = rif.wdata;
                        n.kick = 1'b1;
                    end
                    n.rdata = q.rx;
                end
                default:
                begin
                    n.rdata = 8'h00;
                end
            endcase
        end

        // Master engine, half-bit ticks
        unique case (q.state)
            i2cab_pkg::M_IDLE:
            begin
                if (q.kick && q.master_select_bit && !q.busy)
                begin
                    n.sda_oe_n = 1'b0;
                    n.kick = 1'b0;
                    n.state = i2cab_pkg::M_START;
                end
                else if (q.master_select_bit && q.busy && !scl_i)
                begin
                    // Joins a frame in progress and drives its data
                    n.sda_oe_n = q.bit_n[3] | q.tx[~q.bit_n[2:0]]; // [R05]
                end
            end
            i2cab_pkg::M_START:
            begin
                if (tick)
                begin
                    n.scl_oe_n = 1'b0;
                    n.state = i2cab_pkg::M_LOW;
                end
            end
            i2cab_pkg::M_LOW:
            begin
                if (tick)
                begin
                    n.sda_oe_n = q.bit_n[3] | q.tx[~q.bit_n[2:0]];
                    n.scl_oe_n = 1'b1;
                    n.state = i2cab_pkg::M_HIGH;
                end
            end
            i2cab_pkg::M_HIGH:
            begin
                if (tick && scl_i)
                begin
                    n.scl_oe_n = 1'b0;
                    n.state = (q.bit_n == 4'h0) ? i2cab_pkg::M_WAIT : i2cab_pkg::M_LOW;
                end
            end
            i2cab_pkg::M_WAIT:
            begin
                if (q.kick && q.master_select_bit)
                begin
                    n.kick = 1'b0;
                    n.state = i2cab_pkg::M_LOW;
                end
                else if (!q.master_select_bit)
                begin
                    n.sda_oe_n = 1'b0;
                    n.state = i2cab_pkg::M_STOP;
                end
            end
            i2cab_pkg::M_STOP:
            begin
                if (tick)
                begin
                    n.scl_oe_n = 1'b1;
                    n.state = i2cab_pkg::M_STOP2;
                end
            end
            i2cab_pkg::M_STOP2:
            begin
                if (tick)
                begin
                    n.sda_oe_n = 1'b1;
                    n.state = i2cab_pkg::M_IDLE;
                end
            end
            default:
            begin
                n.state = i2cab_pkg::M_IDLE;
            end
        endcase

        // Bus monitor: start, stop, bit capture
        if (start)
        begin
            n.busy = 1'b1;
            n.bit_n = 4'h0;
            n.expect_addr = 1'b1;
        end
        else if (stop)
        begin
            n.busy = 1'b0;
            n.bit_n = 4'h0;
        end
        else if (rise && q.busy)
        begin
            if (lost)
            begin
                n.al = 1'b1;
                n.master_select_bit = 1'b0; // [R01]
                n.kick = 1'b0;
                n.scl_oe_n = 1'b1; // [R09]
                n.sda_oe_n = 1'b1; // [R09]
                n.state = i2cab_pkg::M_IDLE;
                n.expect_addr = 1'b1; // [R01]
            end
            if (!q.bit_n[3])
            begin
                n.rx = {q.rx[6:0], sda_i};
            end
            if (q.bit_n == 4'h7 && n.expect_addr)
            begin
                // Slave compares the byte as an address, genuine or not
                if (!n.master_select_bit && (n.rx[7:1] == q.own || n.rx[7:1] == q.sec)) // [R02]
                begin
                    n.call = 1'b1; // [R03]
                end
                n.expect_addr = 1'b0;
            end
            if (q.bit_n == i2cab_pkg::ACK_BIT)
            begin
                n.bit_n = 4'h0;
                n.frm = 1'b1;
            end
            else
            begin
                n.bit_n = q.bit_n + 4'h1;
            end
        end
    end

    // ----
    // Registers
    // ----
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{scl_oe_n: 1'b1, sda_oe_n: 1'b1, scl_p: 1'b1, sda_p: 1'b1,
                state: i2cab_pkg::M_IDLE, default: '0};
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs straight from flops; open drain drives low only
    assign scl_oe_n = q.scl_oe_n;
    assign sda_oe_n = q.sda_oe_n;
    assign scl_o = q.ack & 1'b0;
    assign sda_o = q.ack & 1'b0;
    assign rif.rdata = q.rdata;
    assign rif.ack = q.ack;

endmodule // i2cab_dev
`default_nettype wire

// ==== src/i2cab_host.sv ====
// Controller that sequences the bus interface for software over APB
`timescale 1ns/1ps
`default_nettype none
module i2cab_host (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Device register port
    i2cab_reg_if.host rif
);

    // ----
    // State
    // ----
    typedef struct packed {
        i2cab_pkg::i2cab_host_t state;
        logic pend;
        logic req;
        logic wr;
        logic [2:0] sel;
        logic [7:0] wdata;
        logic [7:0] data;
        logic [13:0] addr;
        logic [4:0] stat;
        logic [4:0] mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } i2cab_host_st_t;

    i2cab_host_st_t q;
    i2cab_host_st_t n;
    logic acc;

    // Access phase completes on this edge
    assign acc = psel && penable && q.pready;

    // ----
    // Next state
    // ----
    // APB slave, event flags, device sequencer
    always_comb
    begin
        n = q;
        n.req = 1'b0;
        n.pready = psel && penable && !q.pready;
        n.pslverr = 1'b0;

        // Read data and error prepared for the answer cycle
        if (psel && penable && !q.pready)
        begin
            n.prdata = 32'h0000_0000;
            unique case (paddr)
                i2cab_pkg::A_CMD: n.prdata = 32'h0000_0000;
                i2cab_pkg::A_STAT: n.prdata = {31'h0000_0000, q.state != i2cab_pkg::H_IDLE};
                i2cab_pkg::A_IRQ: n.prdata = {27'h0000000, q.stat};
                i2cab_pkg::A_MASK: n.prdata = {27'h0000000, q.mask};
                i2cab_pkg::A_ADDR: n.prdata = {18'h00000, q.addr};
                default: n.pslverr = 1'b1;
            endcase
        end

        // Writes land on the completing edge; clear before set
        if (acc && pwrite)
        begin
            if (paddr == i2cab_pkg::A_IRQ)
            begin
                n.stat = q.stat & ~pwdata[4:0];
            end
            if (paddr == i2cab_pkg::A_MASK)
            begin
                n.mask = pwdata[4:0];
            end
            if (paddr == i2cab_pkg::A_ADDR)
            begin
                n.addr = pwdata[13:0];
            end
            if (paddr == i2cab_pkg::A_CMD && q.state == i2cab_pkg::H_IDLE)
            begin
                n.data = pwdata[15:8];
                unique case (pwdata[2:0])
                    i2cab_pkg::OP_ENTER: n.state = i2cab_pkg::H_CHK1;
                    i2cab_pkg::OP_SEND: n.state = i2cab_pkg::H_TX;
                    i2cab_pkg::OP_STOP: n.state = i2cab_pkg::H_STOP;
                    i2cab_pkg::OP_CFG: n.state = i2cab_pkg::H_CFG1;
                    default: n.state = i2cab_pkg::H_IDLE;
                endcase
            end
        end

        // Issue one device access per step
        if (q.state != i2cab_pkg::H_IDLE && !q.pend)
        begin
            n.req = 1'b1;
            n.pend = 1'b1;
            n.wr = 1'b1;
            n.sel = i2cab_pkg::REG_CTRL;
            n.wdata = 8'h00;
            unique case (q.state)
                i2cab_pkg::H_CHK1, i2cab_pkg::H_CHK2: n.wr = 1'b0;
                i2cab_pkg::H_SETM: n.wdata = 8'h01 << i2cab_pkg::CTRL_MST; // [R07]
                i2cab_pkg::H_TX:
                begin
                    n.sel = i2cab_pkg::REG_DATA;
                    n.wdata = q.data;
                end
                i2cab_pkg::H_POLL:
                begin
                    n.sel = i2cab_pkg::REG_STAT;
                    n.wr = 1'b0;
                end
                i2cab_pkg::H_CLR:
                begin
                    n.sel = i2cab_pkg::REG_STAT;
                    n.wdata = i2cab_pkg::ST_ALL;
                end
                i2cab_pkg::H_CFG1:
                begin
                    n.sel = i2cab_pkg::REG_OWN;
                    n.wdata = {1'b0, q.addr[6:0]};
                end
                i2cab_pkg::H_CFG2:
                begin
                    n.sel = i2cab_pkg::REG_SEC;
                    n.wdata = {1'b0, q.addr[13:7]};
                end
                default: n.wdata = 8'h00;
            endcase
        end
        else if (q.pend && rif.ack)
        begin
            // Answer arrived: decide the next step
            n.pend = 1'b0;
            n.state = i2cab_pkg::H_IDLE;
            unique case (q.state)
                i2cab_pkg::H_CHK1:
                begin
                    if (rif.rdata[i2cab_pkg::CTRL_BUSY]) // [R06]
                    begin
                        n.stat[i2cab_pkg::EV_REFUSE] = 1'b1;
                    end
                    else
                    begin
                        n.state = i2cab_pkg::H_SETM;
                    end
                end
                i2cab_pkg::H_SETM: n.state = i2cab_pkg::H_CHK2; // [R07]
                i2cab_pkg::H_CHK2:
                begin
                    if (rif.rdata[i2cab_pkg::CTRL_BUSY]) // [R08]
                    begin
                        n.state = i2cab_pkg::H_DROP;
                    end
                    else
                    begin
                        n.stat[i2cab_pkg::EV_MST] = 1'b1;
                    end
                end
                i2cab_pkg::H_DROP: n.stat[i2cab_pkg::EV_REFUSE] = 1'b1; // [R05]
                i2cab_pkg::H_TX: n.state = i2cab_pkg::H_POLL;
                i2cab_pkg::H_POLL:
                begin
                    n.state = i2cab_pkg::H_POLL;
                    if (rif.rdata[i2cab_pkg::ST_FRM])
                    begin
                        // Lost flag checked once each frame ends
                        n.stat[i2cab_pkg::EV_LOST] = rif.rdata[i2cab_pkg::ST_AL]; // [R04]
                        n.stat[i2cab_pkg::EV_DONE] = !rif.rdata[i2cab_pkg::ST_AL];
                        n.stat[i2cab_pkg::EV_CALL] = rif.rdata[i2cab_pkg::ST_CALL];
                        n.state = i2cab_pkg::H_CLR;
                    end
                end
                i2cab_pkg::H_CFG1: n.state = i2cab_pkg::H_CFG2;
                default: n.state = i2cab_pkg::H_IDLE;
            endcase
        end

        n.irq = |(n.stat & n.mask);
    end

    // ----
    // Registers
    // ----
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '{state: i2cab_pkg::H_IDLE, default: '0};
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs straight from flops
    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign irq = q.irq;
    assign rif.req = q.req;
    assign rif.wr = q.wr;
    assign rif.sel = q.sel;
    assign rif.wdata = q.wdata;

endmodule // i2cab_host
`default_nettype wire

// ==== tb/i2cab_props.sv ====
// Checker for the register port between controller and bus interface
`timescale 1ns/1ps
`default_nettype none
module i2cab_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register port
    input wire logic req,
    input wire logic wr,
    input wire logic [2:0] sel,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    // ----
    // Sequence tracking
    // ----
    logic lwr_q, busy_q, ctrd_q, set_q, rck_q, drop_q, tx_q, clr_q;
    logic [2:0] lsel_q;
    wire logic rd_ack = ack && !lwr_q;
    wire logic ctl_set = req && wr && sel == i2cab_pkg::REG_CTRL && wdata[i2cab_pkg::CTRL_MST];

    // Remember the last request and what its answer showed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            {lwr_q, busy_q, ctrd_q, set_q, rck_q, drop_q, tx_q, clr_q} <= '0;
            lsel_q <= '0;
        end
        else
        begin
            if (req)
            begin
                lwr_q <= wr;
                lsel_q <= sel;
                ctrd_q <= !wr && sel == i2cab_pkg::REG_CTRL;
                set_q <= ctl_set;
                rck_q <= set_q;
                drop_q <= 1'b0;
                clr_q <= 1'b0;
                if (wr && sel == i2cab_pkg::REG_DATA)
                    tx_q <= 1'b1;
            end
            if (rd_ack && lsel_q == i2cab_pkg::REG_CTRL)
            begin
                busy_q <= rdata[i2cab_pkg::CTRL_BUSY];
                drop_q <= rck_q && rdata[i2cab_pkg::CTRL_BUSY];
            end
            if (rd_ack && lsel_q == i2cab_pkg::REG_STAT && tx_q && rdata[i2cab_pkg::ST_FRM])
            begin
                tx_q <= 1'b0;
                clr_q <= 1'b1;
            end
        end
    end

    // ----
    // Properties
    // ----
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ack_next;
        req |=> ack;
    endproperty
    property p_ack_cause;
        ack |-> $past(req);
    endproperty
    property p_free_first;
        ctl_set |-> ctrd_q && !busy_q;
    endproperty
    property p_recheck;
        req && set_q |-> !wr && sel == i2cab_pkg::REG_CTRL;
    endproperty
    property p_drop;
        req && drop_q |-> wr && sel == i2cab_pkg::REG_CTRL && !wdata[i2cab_pkg::CTRL_MST];
    endproperty
    property p_poll;
        req && tx_q |-> !wr && sel == i2cab_pkg::REG_STAT;
    endproperty
    property p_clear;
        req && clr_q |-> wr && sel == i2cab_pkg::REG_STAT && wdata == i2cab_pkg::ST_ALL;
    endproperty
    property p_mapped;
        req |-> sel <= i2cab_pkg::REG_DATA;
    endproperty

    a_ack_next: assert property (p_ack_next) else $error("ack missing after req");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without req");
    a_free_first: assert property (p_free_first) else $error("master set unchecked");
    a_recheck: assert property (p_recheck) else $error("busy not reread");
    a_drop: assert property (p_drop) else $error("master not dropped");
    a_poll: assert property (p_poll) else $error("frame not polled");
    a_clear: assert property (p_clear) else $error("status not cleared");
    a_mapped: assert property (p_mapped) else $error("bad register index");

    // Main scenarios seen
    c_set: cover property (ctl_set);
    c_clear: cover property (req && clr_q);
    c_call: cover property (rd_ack && lsel_q == i2cab_pkg::REG_STAT && rdata[i2cab_pkg::ST_CALL]);
endmodule // i2cab_props
`default_nettype wire

// ==== tb/tb_top.sv ====
// Bench joining controller and bus interface, acting as rival master
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----
    // Signals
    // ----
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, o_scl, o_sda, o_stp, scl_p;
    logic [7:0] ob;
    logic [8:0] sh;
    int bc, fails, checks, cyc;
    wire logic scl_w = (scl_oe_n | scl_o) & o_scl;
    wire logic sda_w = (sda_oe_n | sda_o) & o_sda & o_stp;

    always #2.5 pclk = ~pclk;

    i2cab_reg_if rif();
    i2cab_dev #(.HALF_CYC(4)) u_i2cab_dev (.pclk(pclk), .presetn(presetn), .rif(rif),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n));
    i2cab_host u_i2cab_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .rif(rif));
    i2cab_props u_i2cab_props (.pclk(pclk), .presetn(presetn), .req(rif.req), .wr(rif.wr),
        .sel(rif.sel), .wdata(rif.wdata), .rdata(rif.rdata), .ack(rif.ack));

    // Wire monitor and rival master data, bit set at each clock fall
    always @(posedge pclk)
    begin
        scl_p <= scl_w;
        if (scl_w && !scl_p)
        begin
            sh <= {sh[7:0], sda_w};
            bc <= bc + 1;
        end
        if (!scl_w && scl_p)
            o_sda <= (bc < 8) ? ob[7 - bc] : 1'b1;
        cyc <= cyc + 1;
        if (cyc > 20000)
        begin
            fails++;
            summarize();
        end
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i2cab_pkg::A_CMD, d, r, e);
    endtask

    // Wait for interrupt, compare events, clear them
    task automatic wev(input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        while (irq !== 1'b1)
            @(posedge pclk);
        apb(1'b0, i2cab_pkg::A_IRQ, 32'h0, r, e);
        chk(r, exp);
        apb(1'b1, i2cab_pkg::A_IRQ, exp, r, e);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
    endtask

    // Rival master STOP
    task automatic bstop();
        repeat (4) @(posedge pclk);
        o_scl <= 1'b0;
        o_stp <= 1'b0;
        repeat (4) @(posedge pclk);
        o_scl <= 1'b1;
        repeat (4) @(posedge pclk);
        o_stp <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask

    task automatic summarize();
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [6:0] own, sec, x;
        logic [7:0] d;
        int li, n, m;
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {o_scl, o_sda, o_stp, scl_p, ob, sh, bc, fails, checks, cyc} = {4'hF, 8'hFF, 9'h0, 128'h0};
        void'($urandom(39));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        own = 7'h40 | 7'($urandom & 32'h1E);
        sec = 7'h60 | 7'($urandom & 32'h1E);
        apb(1'b1, i2cab_pkg::A_ADDR, {18'h0, sec, own}, r, e);
        cmd({29'h0, i2cab_pkg::OP_CFG});
        repeat (40) @(posedge pclk);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
        // Busy bus: entry refused, masked then unmasked
        o_stp <= 1'b0;
        repeat (8) @(posedge pclk);
        cmd({29'h0, i2cab_pkg::OP_ENTER});
        repeat (60) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, i2cab_pkg::A_MASK, 32'h1F, r, e);
        wev(32'h1 << i2cab_pkg::EV_REFUSE);
        bstop();
        // Late arbitration loss against own, second and unmatched address
        for (int k = 0; k < 3; k++)
        begin
            x = (k == 0) ? own : (k == 1) ? sec : 7'h7F;
            m = (x == own || x == sec);
            cmd({29'h0, i2cab_pkg::OP_ENTER});
            wev(32'h1 << i2cab_pkg::EV_MST);
            d = 8'($urandom);
            bc = 0;
            cmd({16'h0, d, 5'h0, i2cab_pkg::OP_SEND});
            wev(32'h1 << i2cab_pkg::EV_DONE);
            chk({24'h0, sh[8:1]}, {24'h0, d});
            ob = {x, 1'b0};
            li = 1;
            while (ob[8 - li])
                li++;
            bc = 0;
            o_sda <= ob[7];
            cmd({16'h0, 8'hFF, 5'h0, i2cab_pkg::OP_SEND});
            while (bc < li)
                @(posedge pclk);
            repeat (4) @(posedge pclk);
            chk({30'h0, scl_oe_n, sda_oe_n}, 32'h3);
            n = 0;
            while (bc < 9 && n < 20)
            begin
                repeat (4) @(posedge pclk);
                o_scl <= 1'b0;
                repeat (4) @(posedge pclk);
                o_scl <= 1'b1;
                n++;
            end
            chk({24'h0, sh[8:1]}, {24'h0, ob});
            bstop();
            ob = 8'hFF;
            wev(32'((1 << i2cab_pkg::EV_LOST) | (m << i2cab_pkg::EV_CALL)));
        end
        // Plain entry then release of the bus
        cmd({29'h0, i2cab_pkg::OP_ENTER});
        wev(32'h1 << i2cab_pkg::EV_MST);
        cmd({29'h0, i2cab_pkg::OP_STOP});
        repeat (60) @(posedge pclk);
        chk({30'h0, scl_w, sda_w}, 32'h3);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
